// ---- mb_cmd_checker_asserts.sv ----
// Purpose: Port checks for the event-count and multi-write handler
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Receive ports are not watched; the FIFO is judged by the bench
`timescale 1ns/1ps
module mb_cmd_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        hold_wr,
  input wire logic [15:0] hold_addr,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [15:0] event_count
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_burst_end;
    hold_wr ##1 !hold_wr;
  endsequence
  sequence s_last_taken;
    tx_valid && tx_ready && tx_last && clk_en;
  endsequence
  a_tx_held: assert property (tx_valid && !tx_ready && clk_en |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx moved while stalled");
  a_last_valid: assert property (tx_last |-> tx_valid)
    else $error("tx_last without tx_valid");
  a_reply_ends: assert property (s_last_taken |=> !tx_valid)
    else $error("reply runs past its last char");
  // Guard the edge after reset, where the old count is still in the past value
  a_count_step: assert property (!$past(sys_rst) && !$stable(event_count) |->
    event_count == $past(event_count) + 16'h0001) else $error("event count jumped");
  a_hold_quiet: assert property (hold_wr |-> !tx_valid)
    else $error("write during reply");
  a_addr_step: assert property (hold_wr && $past(hold_wr) |->
    hold_addr == $past(hold_addr) + 16'h0001) else $error("write address not consecutive");
  a_burst_max: assert property (hold_wr [*8] ##1 hold_wr [*8] |=> !hold_wr)
    else $error("more than 16 writes in a burst");
  a_reply_after: assert property (s_burst_end |-> ##[0:16] tx_valid)
    else $error("no reply after writes");
endmodule
bind mb_event_multi_write mb_cmd_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .clk_en(clk_en), .hold_wr(hold_wr), .hold_addr(hold_addr), .tx_data(tx_data),
  .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .event_count(event_count));

// ---- mb_cmd_pkg.sv ----
// Purpose: Shared constants for the event-count and multi-write command handler
// Assumes: Byte-wide telegram characters, Modbus RTU CRC-16
// Notes:   Register numbers are the telegram address values as received
package mb_cmd_pkg;
  localparam logic [7:0]  FC_EVENT_COUNT = 8'h0B;
  localparam logic [7:0]  FC_MULTI_WRITE = 8'h10;
  localparam logic [7:0]  EXC_FC_FLAG    = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [15:0] STATUS_READY   = 16'h0000;
  localparam logic [15:0] STATUS_BUSY    = 16'hFFFF;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] PWD_REG_FIRST  = 16'h03E9;
  localparam logic [15:0] PWD_REG_LAST   = 16'h03EB;
  localparam logic [15:0] EVENT_RESET    = 16'h0000;
  localparam logic [3:0]  EVT_REPLY_LEN  = 4'h8;
  localparam logic [3:0]  MW_REPLY_LEN   = 4'h8;
  localparam logic [3:0]  EXC_REPLY_LEN  = 4'h5;
  localparam logic [3:0]  MW_HDR_LEN     = 4'h7;
  localparam int          FIFO_DEPTH     = 32;
endpackage

// ---- mb_event_multi_write.sv ----
// Purpose: Handles function 0x0B (event counter) and 0x10 (multi-register write)
// Assumes: Frame characters arrive with a last flag; address already matched upstream
// Notes:   Register storage lives outside; writes leave on the hold_wr port
`timescale 1ns/1ps
module mb_event_multi_write #(
  parameter int          DEPTH     = mb_cmd_pkg::FIFO_DEPTH,
  parameter logic [15:0] WIDE_FIRST = 16'h0BB9,
  parameter logic [15:0] WIDE_LAST  = 16'h1387
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic             hold_wr,
  output logic [15:0]      hold_addr,
  output logic [15:0]      hold_data,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [15:0]      event_count
);
  typedef enum logic [1:0] {
    ST_RECV  = 2'b00,
    ST_WRITE = 2'b01,
    ST_REPLY = 2'b10
  } state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mb_cmd_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [8:0]  f_data;
  logic        f_valid, f_ready;
  logic [7:0]  frame [64];

  state_t      st_reg, st_next;
  logic [5:0]  idx_reg, idx_next;
  logic [15:0] crc_reg, crc_next;
  logic [15:0] evt_reg, evt_next;
  logic [7:0]  fc_reg, fc_next;
  logic        ovf_reg, ovf_next;
  logic [6:0]  wi_reg, wi_next;
  logic [3:0]  ti_reg, ti_next, tlen_reg, tlen_next;
  logic [7:0]  txd_reg, txd_next;
  logic        txv_reg, txv_next, txl_reg, txl_next;
  logic        hw_reg, hw_next;
  logic [15:0] ha_reg, ha_next, hd_reg, hd_next, tcrc_reg, tcrc_next;
  logic [15:0] start_a, nregs, last_a;
  logic        f_take, good_mw, pwd_hit, wide_bad, crc_ok;
  logic [7:0]  tb;

  mb_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   ({rx_last, rx_data}),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // Frame bytes land in a buffer; while we write or reply the FIFO keeps taking characters and stalls the link only when full
  assign f_ready = (st_reg == ST_RECV);
  assign f_take  = f_valid && f_ready;

  always_ff @(posedge clk_sys) begin
    if (clk_en && f_take && !ovf_reg) begin
      frame[idx_reg] <= f_data[7:0];
    end
  end

  always_comb begin
    start_a = {frame[2], frame[3]};
    nregs   = {frame[4], frame[5]};
    last_a  = 16'(start_a + nregs - 16'h0001);
    pwd_hit = (start_a <= mb_cmd_pkg::PWD_REG_LAST) &&
              (last_a >= mb_cmd_pkg::PWD_REG_FIRST);
    wide_bad = (start_a >= WIDE_FIRST) && (start_a <= WIDE_LAST) && nregs[0];
    good_mw = (nregs != 16'h0000) && (nregs <= 16'h0010) &&
              (frame[6] == 8'(nregs << 1)) &&
              (idx_reg == 6'(mb_cmd_pkg::MW_HDR_LEN + 2 * nregs + 1));
    // Residue over data plus its own CRC is zero; taken from the register, not the
    // next value, which the last character overwrites with the seed
    crc_ok  = (crc_step(crc_reg, f_data[7:0]) == 16'h0000);
  end

  // Reply character picked by index; CRC bytes appended after the body
  always_comb begin
    tb = 8'h00;
    unique case (ti_reg)
      4'h0: tb = frame[0];
      4'h1: tb = fc_reg;
      4'h2: tb = (fc_reg == mb_cmd_pkg::FC_EVENT_COUNT) ? mb_cmd_pkg::STATUS_READY[15:8]
               : (fc_reg[7] ? mb_cmd_pkg::EXC_ILLEGAL_ADDR : frame[2]);
      4'h3: tb = (fc_reg == mb_cmd_pkg::FC_EVENT_COUNT) ? mb_cmd_pkg::STATUS_READY[7:0]
               : frame[3];
      4'h4: tb = (fc_reg == mb_cmd_pkg::FC_EVENT_COUNT) ? evt_reg[15:8] : frame[4];
      4'h5: tb = (fc_reg == mb_cmd_pkg::FC_EVENT_COUNT) ? evt_reg[7:0] : frame[5];
      default: tb = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;   idx_next = idx_reg; crc_next = crc_reg; evt_next = evt_reg;
    fc_next = fc_reg;   ovf_next = ovf_reg; wi_next = wi_reg;   ti_next = ti_reg;
    tlen_next = tlen_reg; txd_next = txd_reg; txv_next = txv_reg; txl_next = txl_reg;
    hw_next = 1'b0;     ha_next = ha_reg;   hd_next = hd_reg;   tcrc_next = tcrc_reg;
    unique case (st_reg)
      ST_RECV: begin
        if (f_take) begin
          crc_next = crc_step(crc_reg, f_data[7:0]);
          idx_next = (idx_reg == 6'h3F) ? idx_reg : 6'(idx_reg + 1'b1);
          ovf_next = ovf_reg || (idx_reg == 6'h3F);
          if (f_data[8]) begin
            idx_next = 6'h00;
            crc_next = mb_cmd_pkg::CRC_INIT;
            ovf_next = 1'b0;
            ti_next  = 4'h0;
            tcrc_next = mb_cmd_pkg::CRC_INIT;
            if (crc_ok && !ovf_reg) begin
              if (frame[1] == mb_cmd_pkg::FC_EVENT_COUNT && idx_reg == 6'h03) begin
                fc_next   = mb_cmd_pkg::FC_EVENT_COUNT;
                tlen_next = mb_cmd_pkg::EVT_REPLY_LEN;
                st_next   = ST_REPLY;
                // Query itself completes without error, counted before the reply
                evt_next  = 16'(evt_reg + 1'b1);
              end else if (frame[1] == mb_cmd_pkg::FC_MULTI_WRITE && good_mw) begin
                if (pwd_hit || wide_bad) begin
                  fc_next   = mb_cmd_pkg::FC_MULTI_WRITE | mb_cmd_pkg::EXC_FC_FLAG;
                  tlen_next = mb_cmd_pkg::EXC_REPLY_LEN;
                  st_next   = ST_REPLY;
                end else begin
                  fc_next = mb_cmd_pkg::FC_MULTI_WRITE;
                  wi_next = 7'h00;
                  st_next = ST_WRITE;
                end
              end
            end
          end
        end
      end
      ST_WRITE: begin
        hw_next = 1'b1;
        ha_next = 16'(start_a + {9'h000, wi_reg});
        hd_next = {frame[6'(mb_cmd_pkg::MW_HDR_LEN + 2 * wi_reg)],
                   frame[6'(mb_cmd_pkg::MW_HDR_LEN + 2 * wi_reg + 1)]};
        wi_next = 7'(wi_reg + 1'b1);
        if (16'(wi_reg + 1'b1) == nregs) begin
          tlen_next = mb_cmd_pkg::MW_REPLY_LEN;
          evt_next  = 16'(evt_reg + 1'b1);
          st_next   = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (!txv_reg || tx_ready) begin
          if (ti_reg == tlen_reg) begin
            txv_next = 1'b0;
            txl_next = 1'b0;
            st_next  = ST_RECV;
          end else begin
            txv_next = 1'b1;
            txl_next = (ti_reg == 4'(tlen_reg - 1'b1));
            ti_next  = 4'(ti_reg + 1'b1);
            if (ti_reg == 4'(tlen_reg - 2'd2)) begin
              txd_next = tcrc_reg[7:0];
            end else if (ti_reg == 4'(tlen_reg - 1'b1)) begin
              txd_next = tcrc_reg[15:8];
            end else begin
              txd_next  = tb;
              tcrc_next = crc_step(tcrc_reg, tb);
            end
          end
        end
      end
      default: st_next = ST_RECV;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= ST_RECV;  idx_reg <= 6'h00; crc_reg <= mb_cmd_pkg::CRC_INIT;
      evt_reg <= mb_cmd_pkg::EVENT_RESET;   fc_reg <= 8'h00; ovf_reg <= 1'b0;
      wi_reg <= 7'h00;    ti_reg <= 4'h0;   tlen_reg <= 4'h0; txd_reg <= 8'h00;
      txv_reg <= 1'b0;    txl_reg <= 1'b0;  hw_reg <= 1'b0;
      ha_reg <= 16'h0000; hd_reg <= 16'h0000; tcrc_reg <= mb_cmd_pkg::CRC_INIT;
    end else if (clk_en) begin
      st_reg <= st_next;  idx_reg <= idx_next; crc_reg <= crc_next;
      evt_reg <= evt_next; fc_reg <= fc_next; ovf_reg <= ovf_next;
      wi_reg <= wi_next;  ti_reg <= ti_next;  tlen_reg <= tlen_next; txd_reg <= txd_next;
      txv_reg <= txv_next; txl_reg <= txl_next; hw_reg <= hw_next;
      ha_reg <= ha_next;  hd_reg <= hd_next;  tcrc_reg <= tcrc_next;
    end
  end

  assign hold_wr     = hw_reg;
  assign hold_addr   = ha_reg;
  assign hold_data   = hd_reg;
  assign tx_data     = txd_reg;
  assign tx_valid    = txv_reg;
  assign tx_last     = txl_reg;
  assign event_count = evt_reg;
endmodule

// ---- mb_fifo.sv ----
// Purpose: Synchronous valid/ready FIFO for received telegram characters
// Assumes: One clock, synchronous active-high reset
// Notes:   Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
module mb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  logic             ready_reg, ready_next;

  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
    // Registered so the ready pin comes straight from a flip-flop
    ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end else if (clk_en) begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = ready_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
endmodule

// ---- mb_master_model.sv ----
// Purpose: Polling master facing the handler's telegram ports
// Assumes: Characters change at the falling edge and wait for ready
// Notes:   A released data line shows the inverse, never the stale byte
`timescale 1ns/1ps
module mb_master_model (
  input  wire logic       clk_sys,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       hold_off = 1'b0;
  logic       slow = 1'b0;
  int         last_at = -1;
  initial {rx_data, rx_last, rx_valid, tx_ready} = 11'h000;
  // Slow mode raises ready only every other cycle to stress the hold rule
  always @(negedge clk_sys) tx_ready <= !hold_off && !(slow && tx_ready);
  // Position of the char flagged last, so the bench can judge the end marker
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      if (tx_last) last_at = got.size();
      got.push_back(tx_data);
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic put(input logic [7:0] b, input logic last);
    @(negedge clk_sys);
    rx_data = b;
    rx_last = last;
    rx_valid = 1'b1;
    @(posedge clk_sys);
    while (!rx_ready) @(posedge clk_sys);
  endtask
  task automatic idle();
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {16{bad}};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) put(f[i], i == f.size() - 1);
    idle();
  endtask
  task automatic fill(output int n);
    n = 0;
    @(negedge clk_sys);
    rx_valid = 1'b1;
    @(posedge clk_sys);
    while (rx_ready && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    idle();
  endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the event-count and multi-write handler
// Assumes: 50 MHz clock, clk_en held high, master model on the telegram side
// Notes:   Counter wrap needs 65536 requests, so only single steps are seen
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst, clk_en, rx_last, rx_valid, rx_ready, hold_wr;
  logic        tx_last, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] hold_addr, hold_data, event_count;
  logic [15:0] cnt = 16'h0000;
  logic [31:0] wr_q[$];
  int          fails = 0;
  int          samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  mb_event_multi_write dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .hold_wr(hold_wr), .hold_addr(hold_addr), .hold_data(hold_data), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .event_count(event_count));
  mb_master_model u_m (.clk_sys(clk_sys), .rx_data(rx_data), .rx_last(rx_last),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  always @(posedge clk_sys) if (hold_wr === 1'b1) wr_q.push_back({hold_addr, hold_data});
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rx_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    int i;
    c = u_m.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (i = 0; i < 400 && u_m.got.size() < e.size(); i++) @(posedge clk_sys);
    chk("reply_len", 16'(e.size()), 16'(u_m.got.size()));
    chk("reply_last", 16'(e.size() - 1), 16'(u_m.last_at));
    foreach (e[k]) if (k < u_m.got.size()) chk("reply_char", {8'h00, e[k]}, {8'h00, u_m.got[k]});
    u_m.got.delete();
    u_m.last_at = -1;
  endtask
  task automatic no_reply();
    repeat (80) @(posedge clk_sys);
    chk("reply_len", 16'h0000, 16'(u_m.got.size()));
    u_m.got.delete();
  endtask
  task automatic t_query();
    cnt++;
    u_m.send('{8'h01, mb_cmd_pkg::FC_EVENT_COUNT}, 1'b0);
    rx_reply('{8'h01, 8'h0B, 8'h00, 8'h00, cnt[15:8], cnt[7:0]});
  endtask
  // kind: 0 accepted, 1 refused with an exception, 2 dropped silently
  task automatic mw(input logic [15:0] a, input int n, input int bc, input int kind);
    logic [7:0] f[$];
    f = '{8'h01, mb_cmd_pkg::FC_MULTI_WRITE, a[15:8], a[7:0], 8'h00, 8'(n), 8'(bc)};
    for (int i = 0; i < n; i++) f = {f, 8'hA5, 8'(i)};
    wr_q.delete();
    u_m.send(f, 1'b0);
    if (kind == 0) cnt++;
    if (kind == 0) rx_reply('{8'h01, 8'h10, a[15:8], a[7:0], 8'h00, 8'(n)});
    if (kind == 1) rx_reply('{8'h01, 8'h90, mb_cmd_pkg::EXC_ILLEGAL_ADDR});
    if (kind == 2) no_reply();
    chk("writes", 16'(kind == 0 ? n : 0), 16'(wr_q.size()));
    foreach (wr_q[i]) chk("wr_addr", a + 16'(i), wr_q[i][31:16]);
    foreach (wr_q[i]) chk("wr_data", {8'hA5, 8'(i)}, wr_q[i][15:0]);
    chk("event_count", cnt, event_count);
  endtask
  task automatic t_write();
    u_m.slow = 1'b1;
    mw(16'h03FC, 2, 4, 0);
    u_m.slow = 1'b0;
  endtask
  task automatic t_pwd();
    for (int i = 0; i < 3; i++) mw(mb_cmd_pkg::PWD_REG_FIRST + 16'(i), 1, 2, 1);
  endtask
  task automatic t_fill();
    int n;
    u_m.hold_off = 1'b1;
    cnt++;
    u_m.send('{8'h01, mb_cmd_pkg::FC_EVENT_COUNT}, 1'b0);
    repeat (10) @(posedge clk_sys);
    u_m.fill(n);
    chk("fifo_room", 16'(mb_cmd_pkg::FIFO_DEPTH), 16'(n));
    u_m.hold_off = 1'b0;
    rx_reply('{8'h01, 8'h0B, 8'h00, 8'h00, cnt[15:8], cnt[7:0]});
    u_m.send('{8'h00}, 1'b1);
    no_reply();
  endtask
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    chk("event_count", 16'h0000, event_count);
    t_query();
    t_write();
    mw(16'h0100, 16, 32, 0);
    t_query();
    u_m.send('{8'h01, 8'h0B}, 1'b1);
    no_reply();
    t_pwd();
    mw(16'h0BB9, 3, 6, 1);
    mw(16'h03FC, 2, 5, 2);
    t_fill();
    t_query();
    final_report();
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule
